// >>> ddl_regs.svh
// constants for the dual dac serial load logic
// assumes inclusion by the package and the top module
`ifndef DDL_REGS_SVH
`define DDL_REGS_SVH
`define DDL_WIDTH_WIDE 12
`define DDL_WIDTH_NARROW 10
`define DDL_SYNC_LEN 3
`define DDL_ZERO_12 12'h0000
`define DDL_MID_12 12'h0800
`define DDL_SYNC_MID 1
`define DDL_SYNC_LAST 2
`define DDL_PIN_COUNT 5
`define DDL_PIN_LOAD_A 0
`define DDL_PIN_LOAD_B 1
`define DDL_PIN_PRESET 2
`define DDL_PIN_MIDSCALE 3
`define DDL_PIN_POWER 4
`define DDL_PIN_IDLE 5'h17
`define DDL_CHANNELS 2
`define DDL_CH_A 0
`define DDL_CH_B 1
`endif

// >>> ddl_pkg.sv
// types for the dual dac serial load logic
// assumes ddl_regs.svh is on the include path
`include "ddl_regs.svh"
package ddl_pkg;
  typedef logic [`DDL_WIDTH_WIDE-1:0] ddl_word_type;
  typedef enum logic [0:0]
  {
    DDL_WIDE = 1'b0,
    DDL_NARROW = 1'b1
  } ddl_variant_type;
endpackage : ddl_pkg

// >>> ddl_top.sv
// serial shift register and two dac registers of a dual dac
// assumes the host drives all pins; serial clock is the link clock
//
// Operation
// - chip select low: each rising serial clock shifts serial_in in.
// - load strobe low copies shift word into its dac register, transparent.
// - reset low with midscale select low forces dac registers to zero.
// - reset low with midscale select high presets dac registers to half scale.
// - wide variant: 12-bit word, bit 11 sent first.
// - narrow variant: 10-bit word, bit 9 sent first.
// - power down changes no register; loading still works.
// - chip select high does not affect the load strobes.
`timescale 1ns/1ps
`include "ddl_regs.svh"
module ddl_top #(
  parameter ddl_pkg::ddl_variant_type variant = ddl_pkg::DDL_WIDE
) (
  input wire logic mclk, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic serial_clk, // link clock from host
  input wire logic chip_select_n, // enables shifting when low
  input wire logic serial_in, // serial data, msb first
  input wire logic load_strobe_a_n, // dac a load, level, active low
  input wire logic load_strobe_b_n, // dac b load, level, active low
  input wire logic async_preset_n, // reset of dac registers, active low
  input wire logic midscale_sel, // preset value select
  input wire logic power_down_n, // shutdown, active low
  output logic [`DDL_WIDTH_WIDE-1:0] dac_a, // dac a register
  output logic [`DDL_WIDTH_WIDE-1:0] dac_b, // dac b register
  output logic powered // output stage enabled
);
  localparam int wbits = (variant == ddl_pkg::DDL_WIDE) ? `DDL_WIDTH_WIDE : `DDL_WIDTH_NARROW;

  // idle level of every synchronised pin, so that no false strobe,
  // preset or power down is seen in the cycles right after rst
  localparam logic [`DDL_PIN_COUNT-1:0] pin_idle = `DDL_PIN_IDLE;

  // link domain: shift register clocked by serial_clk

  logic [`DDL_WIDTH_WIDE-1:0] shift_word;
  logic [`DDL_WIDTH_WIDE-1:0] next_shift_word;

  // no reset in this domain: the link clock only runs inside frames, and
  // a full word shifted in overwrites whatever power-up left behind
  always_comb
  begin
    next_shift_word = shift_word;
    if (!chip_select_n)
    begin
      // msb first: earlier bits move towards the top
      next_shift_word = {shift_word[`DDL_WIDTH_WIDE-2:0], serial_in};
    end
    // narrow variant keeps the unused upper bits clear
    for (int i = 0; i < `DDL_WIDTH_WIDE; i++)
    begin
      if (i >= wbits)
      begin
        next_shift_word[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge serial_clk)
  begin
    shift_word <= next_shift_word;
  end

  // word crossing into the mclk domain

  // the host keeps serial_clk idle while a strobe is low, and a strobe
  // passes three flops before it acts, so both capture stages hold a
  // settled word by then; a word that moves under a low strobe is a
  // host fault and may reach a dac register torn
  logic [`DDL_WIDTH_WIDE-1:0] word_s1;
  logic [`DDL_WIDTH_WIDE-1:0] word_s2;
  logic [`DDL_WIDTH_WIDE-1:0] next_word_s1;
  logic [`DDL_WIDTH_WIDE-1:0] next_word_s2;

  always_comb
  begin
    next_word_s1 = shift_word;
    next_word_s2 = word_s1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      word_s1 <= `DDL_ZERO_12;
      word_s2 <= `DDL_ZERO_12;
    end
    else
    begin
      word_s1 <= next_word_s1;
      word_s2 <= next_word_s2;
    end
  end

  // pin synchronisers

  logic [`DDL_PIN_COUNT-1:0] pin_raw;
  logic [`DDL_PIN_COUNT-1:0] pin_low;
  logic [`DDL_PIN_COUNT-1:0] pin_high;

  always_comb
  begin
    pin_raw[`DDL_PIN_LOAD_A] = load_strobe_a_n;
    pin_raw[`DDL_PIN_LOAD_B] = load_strobe_b_n;
    pin_raw[`DDL_PIN_PRESET] = async_preset_n;
    pin_raw[`DDL_PIN_MIDSCALE] = midscale_sel;
    pin_raw[`DDL_PIN_POWER] = power_down_n;
  end

  // a level counts only once the second and third stages agree, which
  // rejects a glitch that the first stage alone would pass on
  genvar gp;
  generate
    for (gp = 0; gp < `DDL_PIN_COUNT; gp = gp + 1)
    begin : g_pin
      logic [`DDL_SYNC_LEN-1:0] stages;
      logic [`DDL_SYNC_LEN-1:0] next_stages;

      always_comb
      begin
        next_stages = {stages[`DDL_SYNC_LEN-2:0], pin_raw[gp]};
      end

      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          stages <= {`DDL_SYNC_LEN{pin_idle[gp]}};
        end
        else
        begin
          stages <= next_stages;
        end
      end

      assign pin_low[gp] = !stages[`DDL_SYNC_MID] && !stages[`DDL_SYNC_LAST];
      assign pin_high[gp] = stages[`DDL_SYNC_MID] && stages[`DDL_SYNC_LAST];
    end
  endgenerate

  // decoded controls

  logic preset_on;
  logic [`DDL_CHANNELS-1:0] strobe_on;
  logic [`DDL_WIDTH_WIDE-1:0] preset_word;

  always_comb
  begin
    preset_on = pin_low[`DDL_PIN_PRESET];
    strobe_on[`DDL_CH_A] = pin_low[`DDL_PIN_LOAD_A];
    strobe_on[`DDL_CH_B] = pin_low[`DDL_PIN_LOAD_B];
    preset_word = `DDL_ZERO_12;
    // half scale sets only the top bit of the word in use
    if (pin_high[`DDL_PIN_MIDSCALE])
    begin
      preset_word[wbits-1] = 1'b1;
    end
  end

  // dac registers, one per channel

  logic [`DDL_WIDTH_WIDE-1:0] dac_reg [`DDL_CHANNELS];

  genvar gc;
  generate
    for (gc = 0; gc < `DDL_CHANNELS; gc = gc + 1)
    begin : g_chan
      logic [`DDL_WIDTH_WIDE-1:0] next_dac;

      always_comb
      begin
        next_dac = dac_reg[gc];
        // zero or half scale while the preset pin is low
        if (preset_on)
        begin
          next_dac = preset_word;
        end
        // transparent while the strobe is low; no chip select term
        // power down never gates the load
        else if (strobe_on[gc])
        begin
          next_dac = word_s2;
        end
      end

      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          dac_reg[gc] <= `DDL_ZERO_12;
        end
        else
        begin
          dac_reg[gc] <= next_dac;
        end
      end
    end
  endgenerate

  // outputs are the dac flops themselves, no logic in between
  always_comb
  begin
    dac_a = dac_reg[`DDL_CH_A];
    dac_b = dac_reg[`DDL_CH_B];
  end

  // output stage enable

  logic next_powered;

  always_comb
  begin
    next_powered = powered;
    // only the output stage follows power down; registers untouched
    if (pin_high[`DDL_PIN_POWER])
    begin
      next_powered = 1'b1;
    end
    else if (pin_low[`DDL_PIN_POWER])
    begin
      next_powered = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      powered <= 1'b1;
    end
    else
    begin
      powered <= next_powered;
    end
  end
endmodule : ddl_top

// >>> ddl_top_checker.sv
// checks on the dac register outputs and on the powered output
// assumes a bind to ddl_top, wide variant
`timescale 1ns/1ps
module ddl_top_checker (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic load_strobe_a_n, // load a
  input wire logic load_strobe_b_n, // load b
  input wire logic async_preset_n, // preset
  input wire logic midscale_sel, // half
  input wire logic power_down_n, // off
  input wire logic [11:0] dac_a, // dac a
  input wire logic [11:0] dac_b, // dac b
  input wire logic powered // on
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  zero_preset_a: assert property ((!async_preset_n && !midscale_sel)[*7] |-> !dac_a)
    else $error("zero preset lost");
  half_preset_a: assert property ((!async_preset_n && midscale_sel)[*7] |-> dac_b == 12'h800)
    else $error("half preset lost");
  hold_dac_a: assert property ((load_strobe_a_n && async_preset_n)[*7] |=> $stable(dac_a))
    else $error("dac a moved");
  hold_dac_b_a: assert property ((load_strobe_b_n && async_preset_n)[*7] |=> $stable(dac_b))
    else $error("dac b moved");
  preset_wins_a: assert property ((!async_preset_n && midscale_sel && !load_strobe_a_n)[*7]
    |-> dac_a == 12'h800)
    else $error("strobe beat preset");
  power_follow_a: assert property ($stable(power_down_n)[*6] |-> powered == power_down_n)
    else $error("powered wrong");
endmodule : ddl_top_checker
bind ddl_top ddl_top_checker chk_u (.mclk, .rst, .load_strobe_a_n, .load_strobe_b_n,
  .async_preset_n, .midscale_sel, .power_down_n, .dac_a, .dac_b, .powered);

// >>> ddl_host_model.sv
// host side of the serial port
// assumes the caller keeps both strobes high
`timescale 1ns/1ps
module ddl_host_model (
  output logic serial_clk, // link clock
  output logic chip_select_n, // select
  output logic serial_in // data
);
  initial {serial_clk, chip_select_n, serial_in} = 3'b010;
  // caller keeps both strobes high while a frame runs
  task automatic send(input logic [11:0] w, input logic cs_n);
    chip_select_n = cs_n;
    for (int i = 11; i >= 0; i--)
    begin
      serial_in = w[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    // released line must not look valid
    serial_in = ~serial_in;
    chip_select_n = 1'b1;
  endtask : send
endmodule : ddl_host_model

// >>> ddl_top_tb.sv
// bench for ddl_top, wide variant
// assumes the host model drives the serial pins
`timescale 1ns/1ps
module ddl_top_tb;
  logic mclk = 0, rst = 1, load_strobe_a_n = 1, load_strobe_b_n = 1, async_preset_n = 1;
  logic midscale_sel = 0, power_down_n = 1, probe = 0, serial_clk, chip_select_n, serial_in;
  logic powered;
  logic [11:0] dac_a, dac_b, w;
  logic [24:0] expq[$];
  int errors = 0, checked = 0, cycles = 0, seed = 22;
  always #2.5 mclk = ~mclk;
  ddl_top dut_u (.mclk, .rst, .serial_clk, .chip_select_n, .serial_in, .load_strobe_a_n,
    .load_strobe_b_n, .async_preset_n, .midscale_sel, .power_down_n, .dac_a, .dac_b, .powered);
  ddl_host_model host_u (.serial_clk, .chip_select_n, .serial_in);
  task automatic step(input logic [3:0] p, input logic [24:0] e);
    repeat (4) @(negedge mclk);
    {load_strobe_a_n, load_strobe_b_n, async_preset_n, midscale_sel} = p;
    repeat (8) @(negedge mclk);
    expq.push_back(e);
    probe = ~probe;
    {load_strobe_a_n, load_strobe_b_n} = 2'b11;
  endtask : step
  task automatic complete_run;
    if (expq.size() != 0)
      errors++;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  always @(probe)
  begin
    checked++;
    if ({dac_a, dac_b, powered} !== expq[0])
    begin
      errors++;
      $display("Error %0t %h %h", $time, {dac_a, dac_b, powered}, expq[0]);
    end
    void'(expq.pop_front());
  end
  always @(posedge mclk)
    if (++cycles > 3000)
    begin
      errors++;
      complete_run;
    end
  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    w = 12'($random(seed));
    host_u.send(w, 1'b0);
    step(4'b0110, {w, 12'h000, 1'b1});
    host_u.send(~w, 1'b1);
    step(4'b1010, {w, w, 1'b1});
    power_down_n = 1'b0;
    host_u.send(~w, 1'b0);
    step(4'b0111, {~w, w, 1'b0});
    power_down_n = 1'b1;
    step(4'b0001, {24'h800_800, 1'b1});
    step(4'b1111, {24'h800_800, 1'b1});
    step(4'b1100, 25'h1);
    step(4'b1110, 25'h1);
    @(negedge mclk);
    complete_run;
  end
endmodule : ddl_top_tb
